// ===== src/bomc_burst_mode.v
// What this block does
// - Burst stays inside aligned length-sized column group
// - Sequence wraps inside group at boundary
// - Upper column bits pick group, low start
// - One burst length for reads and writes
// - Sixteen-word bursts optional; two four eight kept
// - Mode bit three picks burst type
// - Sequential adds beat, interleaved XORs beat
// - Read latency three default; two, four optional
// - First read data latency cycles after read
// - Extended load: high bank bit set, low bank bit clear
// - Partial refresh field limits refreshed array
// - Refresh options act only in self refresh
// - Bits three four pick temperature refresh rate
// - Internal sensor build ignores bits three four
// - Bits five to seven pick drive strength
// - Base load: both bank bits low
// - Lengths two four eight, both orders
`include "bomc_defs.vh"
module bomc_burst_mode #(
  parameter COL_W = 9,
  parameter HAS_BL16 = 1,
  parameter HAS_RL2 = 1,
  parameter HAS_RL4 = 1,
  parameter INT_TEMP = 0
)
(
  input wire core_clk,
  input wire reset_n,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire cke,
  input wire [1:0] bank_bit,
  input wire [12:0] addr,
  output reg [COL_W-1:0] col_addr_reg,
  output reg col_valid_reg,
  output reg col_is_write_reg,
  output reg col_last_reg,
  output reg read_data_valid_reg,
  output reg mode_reserved_reg,
  output reg [2:0] burst_len_code_reg,
  output reg burst_interleave_reg,
  output reg [2:0] read_latency_reg,
  output reg [2:0] partial_array_refresh_sel_reg,
  output reg [1:0] temp_comp_refresh_sel_reg,
  output reg [2:0] drive_strength_reg,
  output reg self_refresh_reg
);

  // ****************************************
  // Command sampling
  // ****************************************
  // Command pins come from the far side: two flops before use
  // Reset parks the pins as a deselect so no false command follows
  reg [19:0] pin_meta_reg;
  reg [19:0] pin_sync_reg;
  reg cke_prev_reg;
  wire [3:0] cmd;
  wire [1:0] bk;
  wire [12:0] ad;
  wire cke_s;
  wire is_load;
  wire is_rd;
  wire is_wr;

  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta_reg <= 20'h0_000F;
      pin_sync_reg <= 20'h0_000F;
      cke_prev_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= {cke, bank_bit, addr, cs_n, ras_n, cas_n, we_n};
      pin_sync_reg <= pin_meta_reg;
      cke_prev_reg <= pin_sync_reg[19];
    end
  end

  assign cmd = pin_sync_reg[3:0];
  assign ad = pin_sync_reg[16:4];
  assign bk = pin_sync_reg[18:17];
  assign cke_s = pin_sync_reg[19];
  assign is_load = cke_s && (cmd == `BOMC_CMD_LOAD);
  assign is_rd = cke_s && (cmd == `BOMC_CMD_READ);
  assign is_wr = cke_s && (cmd == `BOMC_CMD_WRITE);

  // ****************************************
  // Mode settings
  // ****************************************
  // Reserved codes leave the last legal setting in force
  wire bl_ok;
  wire rl_ok;
  wire [2:0] bl_in;
  wire [2:0] rl_in;
  reg [12:0] extended_mode_settings;
  wire base_hit;
  wire ext_hit;

  assign bl_in = ad[`BOMC_BL_MSB:`BOMC_BL_LSB];
  assign rl_in = ad[`BOMC_RL_MSB:`BOMC_RL_LSB];
  assign bl_ok = (bl_in == `BOMC_BL2) || (bl_in == `BOMC_BL4) ||
                 (bl_in == `BOMC_BL8) ||
                 ((HAS_BL16 != 0) && (bl_in == `BOMC_BL16));
  assign rl_ok = (rl_in == `BOMC_RL3) ||
                 ((HAS_RL2 != 0) && (rl_in == `BOMC_RL2)) ||
                 ((HAS_RL4 != 0) && (rl_in == `BOMC_RL4));

  assign base_hit = is_load && (bk == `BOMC_BANK_BASE);
  assign ext_hit = is_load && (bk == `BOMC_BANK_EXT);

  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      burst_len_code_reg <= `BOMC_BL8;
      burst_interleave_reg <= 1'b0;
      read_latency_reg <= `BOMC_RL3;
      mode_reserved_reg <= 1'b0;
      extended_mode_settings <= `BOMC_EXT_RST;
    end
    else if (base_hit)
    begin
      if (bl_ok)
        burst_len_code_reg <= bl_in;
      burst_interleave_reg <= ad[`BOMC_BT_BIT];
      if (rl_ok)
        read_latency_reg <= rl_in;
      mode_reserved_reg <= !(bl_ok && rl_ok);
    end
    else if (ext_hit)
    begin
      // Sensor builds keep the held rate field whatever bits 4:3 carry
      if (INT_TEMP == 0)
        extended_mode_settings <= ad;
      else
      begin
        extended_mode_settings[`BOMC_EXT_MSB:`BOMC_DRV_LSB] <=
          ad[`BOMC_EXT_MSB:`BOMC_DRV_LSB];
        extended_mode_settings[`BOMC_PARTIAL_ARRAY_REFRESH_SEL_MSB:`BOMC_PARTIAL_ARRAY_REFRESH_SEL_LSB] <=
          ad[`BOMC_PARTIAL_ARRAY_REFRESH_SEL_MSB:`BOMC_PARTIAL_ARRAY_REFRESH_SEL_LSB];
      end
    end
  end

  // ****************************************
  // Extended mode fields
  // ****************************************
  // Fields follow the held word one cycle after a load;
  // the controller's load wait covers that extra cycle
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      partial_array_refresh_sel_reg <= `BOMC_PARTIAL_ARRAY_REFRESH_SEL_FULL;
      temp_comp_refresh_sel_reg <= `BOMC_TEMP_COMP_REFRESH_SEL_DFLT;
      drive_strength_reg <= `BOMC_DRV_FULL;
    end
    else
    begin
      partial_array_refresh_sel_reg <=
        extended_mode_settings[`BOMC_PARTIAL_ARRAY_REFRESH_SEL_MSB:`BOMC_PARTIAL_ARRAY_REFRESH_SEL_LSB];
      temp_comp_refresh_sel_reg <=
        extended_mode_settings[`BOMC_TEMP_COMP_REFRESH_SEL_MSB:`BOMC_TEMP_COMP_REFRESH_SEL_LSB];
      drive_strength_reg <=
        extended_mode_settings[`BOMC_DRV_MSB:`BOMC_DRV_LSB];
    end
  end

  // ****************************************
  // Self refresh
  // ****************************************
  // Refresh selections only steer refresh while self refresh runs
  wire sref_entry;

  assign sref_entry = cke_prev_reg && !cke_s && (cmd == `BOMC_CMD_AREF);

  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      self_refresh_reg <= 1'b0;
    else if (sref_entry)
      self_refresh_reg <= 1'b1;
    else if (cke_s)
      self_refresh_reg <= 1'b0;
  end

  // ****************************************
  // Burst sequencer
  // ****************************************
  reg [3:0] beat_reg;
  reg [3:0] start_reg;
  reg [3:0] len_mask_reg;
  reg [COL_W-1:0] base_reg;
  reg ilv_reg;
  reg busy_reg;
  reg [3:0] mask;
  reg [3:0] off;
  reg [COL_W-1:0] col_in;
  wire last_beat;
  wire bterm_hit;

  // Terminate only cuts read bursts; it is undefined for write bursts
  assign last_beat = (beat_reg == len_mask_reg);
  assign bterm_hit = cke_s && (cmd == `BOMC_CMD_BTERM) && !col_is_write_reg;

  // Mask follows the mode now in force; a burst latches it at start
  always @*
  begin
    case (burst_len_code_reg)
      `BOMC_BL2: mask = 4'h1;
      `BOMC_BL4: mask = 4'h3;
      `BOMC_BL8: mask = 4'h7;
      default: mask = 4'hF;
    endcase
    col_in = ad[COL_W-1:0];
    if (ilv_reg)
      off = (start_reg ^ beat_reg) & len_mask_reg;
    else
      off = (start_reg + beat_reg) & len_mask_reg;
  end

  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      beat_reg <= 4'h0;
      start_reg <= 4'h0;
      len_mask_reg <= 4'h1;
      base_reg <= {COL_W{1'b0}};
      ilv_reg <= 1'b0;
      busy_reg <= 1'b0;
      col_is_write_reg <= 1'b0;
    end
    else if (is_rd || is_wr)
    begin
      // New read or write truncates any running burst
      beat_reg <= 4'h0;
      start_reg <= col_in[3:0] & mask;
      base_reg <= col_in & ~{{(COL_W-4){1'b0}}, mask};
      len_mask_reg <= mask;
      ilv_reg <= burst_interleave_reg;
      busy_reg <= 1'b1;
      col_is_write_reg <= is_wr;
    end
    else if (busy_reg)
    begin
      if (last_beat || bterm_hit)
        busy_reg <= 1'b0;
      beat_reg <= beat_reg + 4'h1;
    end
  end

  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      col_addr_reg <= {COL_W{1'b0}};
      col_valid_reg <= 1'b0;
      col_last_reg <= 1'b0;
    end
    else
    begin
      col_addr_reg <= base_reg | {{(COL_W-4){1'b0}}, off};
      col_valid_reg <= busy_reg;
      col_last_reg <= busy_reg && last_beat;
    end
  end

  // ****************************************
  // Read latency
  // ****************************************
  // Pulse of a read start delayed latency cycles marks first data
  reg [2:0] rd_pipe_reg;
  reg rd_tap;

  // Tap follows the latency in force as the pulse passes
  always @*
  begin
    case (read_latency_reg)
      `BOMC_RL2: rd_tap = rd_pipe_reg[0];
      `BOMC_RL4: rd_tap = rd_pipe_reg[2];
      default: rd_tap = rd_pipe_reg[1];
    endcase
  end

  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_pipe_reg <= 3'h0;
      read_data_valid_reg <= 1'b0;
    end
    else
    begin
      rd_pipe_reg <= {rd_pipe_reg[1:0], is_rd};
      read_data_valid_reg <= rd_tap;
    end
  end

endmodule

// ===== src/bomc_defs.vh
`ifndef BOMC_DEFS_VH
`define BOMC_DEFS_VH
// Command encodings on {cs_n, ras_n, cas_n, we_n}
`define BOMC_CMD_LOAD 4'h0
`define BOMC_CMD_READ 4'h5
`define BOMC_CMD_WRITE 4'h4
`define BOMC_CMD_BTERM 4'h6
`define BOMC_CMD_AREF 4'h1
// Bank bits selecting the mode target
`define BOMC_BANK_BASE 2'h0
`define BOMC_BANK_EXT 2'h2
// Base mode fields
`define BOMC_BL_LSB 0
`define BOMC_BL_MSB 2
`define BOMC_BT_BIT 3
`define BOMC_RL_LSB 4
`define BOMC_RL_MSB 6
// Burst length codes
`define BOMC_BL2 3'h1
`define BOMC_BL4 3'h2
`define BOMC_BL8 3'h3
`define BOMC_BL16 3'h4
// Read latency codes
`define BOMC_RL2 3'h2
`define BOMC_RL3 3'h3
`define BOMC_RL4 3'h4
// Extended mode fields
`define BOMC_PARTIAL_ARRAY_REFRESH_SEL_LSB 0
`define BOMC_PARTIAL_ARRAY_REFRESH_SEL_MSB 2
`define BOMC_TEMP_COMP_REFRESH_SEL_LSB 3
`define BOMC_TEMP_COMP_REFRESH_SEL_MSB 4
`define BOMC_DRV_LSB 5
`define BOMC_DRV_MSB 7
`define BOMC_EXT_MSB 12
// Reset values
`define BOMC_BASE_RST 7'h33
`define BOMC_EXT_RST 13'h0000
`define BOMC_PARTIAL_ARRAY_REFRESH_SEL_FULL 3'h0
`define BOMC_TEMP_COMP_REFRESH_SEL_DFLT 2'h0
`define BOMC_DRV_FULL 3'h0
`endif

// ===== verification/bomc_burst_mode_checker.sv
`include "bomc_defs.vh"
module bomc_chk #(parameter COL_W = 9)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [12:0] addr,
  input wire logic [1:0] bank_bit,
  input wire logic [COL_W-1:0] col_addr_reg,
  input wire logic col_valid_reg,
  input wire logic col_is_write_reg,
  input wire logic col_last_reg,
  input wire logic read_data_valid_reg,
  input wire logic burst_interleave_reg,
  input wire logic [2:0] burst_len_code_reg,
  input wire logic [2:0] read_latency_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Command decode and history
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire base_ld = cmd == `BOMC_CMD_LOAD && bank_bit == `BOMC_BANK_BASE;
  wire ok = addr[2:0] inside {[1:4]} && addr[6:4] inside {[2:4]};
  wire [6:0] pin7 = addr[6:0];
  wire [6:0] mode = {read_latency_reg, burst_interleave_reg,
    burst_len_code_reg};
  wire rd_rise = col_valid_reg && !col_is_write_reg;
  logic [COL_W-1:0] prev;
  always_ff @(posedge core_clk) prev <= col_addr_reg;
  a_rl2_data: assert property (
    $rose(rd_rise) && read_latency_reg == 3'h2 |-> read_data_valid_reg)
    else $error("latency two data misplaced");
  a_rl3_data: assert property (
    $rose(rd_rise) && read_latency_reg == 3'h3
    |-> !read_data_valid_reg ##1 read_data_valid_reg)
    else $error("latency three data misplaced");
  a_rl4_data: assert property (
    $rose(rd_rise) && read_latency_reg == 3'h4
    |-> !read_data_valid_reg [*2] ##1 read_data_valid_reg)
    else $error("latency four data misplaced");
  a_burst_start: assert property (
    cmd == `BOMC_CMD_READ || cmd == `BOMC_CMD_WRITE
    |-> ##[3:4] col_valid_reg)
    else $error("burst did not start");
  a_seq_wrap: assert property (
    col_valid_reg && !col_last_reg && !burst_interleave_reg
    && burst_len_code_reg == `BOMC_BL8 |=> col_addr_reg[2:0] == prev[2:0]
    + 3'h1 && col_addr_reg[COL_W-1:3] == prev[COL_W-1:3])
    else $error("sequential step wrong");
  a_last_pulse: assert property (
    col_last_reg |-> col_valid_reg ##1 !col_last_reg)
    else $error("last beat not a single pulse");
  a_base_load: assert property (
    base_ld && ok |-> ##5 mode == $past(pin7, 5))
    else $error("base mode not loaded");
  a_ext_keeps: assert property (
    cmd == `BOMC_CMD_LOAD && bank_bit != `BOMC_BANK_BASE
    |-> ##5 mode == $past(mode, 5))
    else $error("base mode changed by other load");
  cover property (col_last_reg && burst_interleave_reg);
  cover property (base_ld && !ok);
  cover property (read_data_valid_reg && read_latency_reg == 3'h4);
endmodule
bind bomc_burst_mode bomc_chk #(.COL_W(COL_W)) chk_u (.*);

// ===== verification/bomc_ctrl_model.sv
`include "bomc_defs.vh"
module bomc_ctrl_model
(
  input wire logic core_clk,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic cke,
  output logic [1:0] bank_bit,
  output logic [12:0] addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Command driver
  // ****
  localparam int MODE_LOAD_WAIT = 6;
  initial {cs_n, ras_n, cas_n, we_n, cke, bank_bit, addr} = 20'hF_8000;
  task automatic send(input logic [3:0] c, input logic [1:0] b,
    input logic [12:0] a);
    @(posedge core_clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    bank_bit <= b;
    addr <= a;
    @(posedge core_clk);
    // Deselected: lines flip so a stale value is never mistaken as held
    {cs_n, ras_n, cas_n, we_n} <= 4'hF;
    bank_bit <= ~b;
    addr <= ~a;
    if (c == `BOMC_CMD_LOAD)
      repeat (MODE_LOAD_WAIT) @(posedge core_clk);
  endtask
  // Self refresh entry is clock enable falling with a refresh command
  task automatic self_refresh(input logic enter);
    @(posedge core_clk);
    cke <= !enter;
    {cs_n, ras_n, cas_n, we_n} <= enter ? `BOMC_CMD_AREF : 4'hF;
    @(posedge core_clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'hF;
  endtask
endmodule

// ===== verification/bomc_burst_mode_tb_top.sv
`include "bomc_defs.vh"
module bomc_burst_mode_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  wire cs_n, ras_n, cas_n, we_n, cke, col_valid_reg, col_is_write_reg;
  wire col_last_reg, read_data_valid_reg, mode_reserved_reg;
  wire burst_interleave_reg, self_refresh_reg;
  wire [1:0] bank_bit, temp_comp_refresh_sel_reg;
  wire [12:0] addr;
  wire [8:0] col_addr_reg;
  wire [2:0] burst_len_code_reg, read_latency_reg;
  wire [2:0] partial_array_refresh_sel_reg, drive_strength_reg;
  int fail_count = 0;
  int n_tests = 0;
  int seed = 16;
  logic [9:0] exp_q[$];
  always #10 core_clk = ~core_clk;
  bomc_burst_mode dut_u (.*);
  bomc_ctrl_model ctrl_u (.*);
  // ****
  // Checking
  // ****
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want)
    begin
      fail_count++;
      $display("CHECK FAILED %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(negedge core_clk)
    if (col_valid_reg === 1'b1)
      chk({col_last_reg, col_addr_reg}, exp_q.pop_front());
  task automatic burst(input logic w, input logic [2:0] bl, input logic bt);
    logic [8:0] s;
    logic [3:0] o;
    s = 9'($random(seed));
    for (int k = 0; k < (1 << bl); k++)
    begin
      o = (bt ? s[3:0] ^ 4'(k) : s[3:0] + 4'(k)) & 4'((1 << bl) - 1);
      exp_q.push_back({k == (1 << bl) - 1, s & ~9'((1 << bl) - 1) | 9'(o)});
    end
    ctrl_u.send(w ? `BOMC_CMD_WRITE : `BOMC_CMD_READ, 2'h0, {4'h0, s});
    repeat (24) @(posedge core_clk);
  endtask
  // ****
  // Scenarios
  // ****
  initial
  begin
    logic [7:0] e;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk({burst_len_code_reg, burst_interleave_reg, read_latency_reg},
      7'h33);
    for (int i = 0; i < 8; i++)
    begin
      ctrl_u.send(`BOMC_CMD_LOAD, `BOMC_BANK_BASE,
        {6'h0, 3'(2 + i % 3), i[0], 3'(1 + i / 2)});
      burst(i[1], 3'(1 + i / 2), i[0]);
    end
    chk(mode_reserved_reg, 1'b0);
    $display("test bursts done");
    for (int i = 0; i < 4; i++)
    begin
      e = {3'(i), 2'($random(seed)), 3'(i < 3 ? i : 5)};
      ctrl_u.send(`BOMC_CMD_LOAD, `BOMC_BANK_EXT, {5'h0, e});
      chk({drive_strength_reg, temp_comp_refresh_sel_reg,
        partial_array_refresh_sel_reg}, e);
    end
    $display("test extended done");
    ctrl_u.self_refresh(1'b1);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk(self_refresh_reg, 1'b1);
    ctrl_u.self_refresh(1'b0);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk(self_refresh_reg, 1'b0);
    $display("test self refresh done");
    ctrl_u.send(`BOMC_CMD_LOAD, 2'h1, 13'h0011);
    ctrl_u.send(`BOMC_CMD_LOAD, `BOMC_BANK_BASE, 13'h003F);
    chk(mode_reserved_reg, 1'b1);
    chk({read_latency_reg, burst_interleave_reg, burst_len_code_reg},
      7'h3C);
    burst(1'b0, 3'h4, 1'b1);
    chk(exp_q.size(), 0);
    $display("test refusals done");
    test_done();
  end
  initial
  begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    test_done();
  end
endmodule
